// >>> verification/ecps_host.sv
// Host computer model on the far side of the serial link
`timescale 1ns/10ps
module ecps_host
    import ecps_pkg::*;
(
    input wire logic core_clk,
    input wire logic txd,
    output logic rxd,
    output logic cts_n
);
    logic [7:0] rxq[$];
    logic hold = 1'b0;
    logic bad = 1'b0;
    int bt = 4;
    initial rxd = 1'b1;
    assign cts_n = hold;
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge core_clk);
            rxd <= f[i];
            repeat (bt - 1) @(posedge core_clk);
        end
    endtask
    // Command letter, then X and the line delimiter
    task automatic cmd(input logic [7:0] a);
        send(a);
        send(CH_X);
        send(CH_CR);
        send(CH_LF);
    endtask
    always begin
        logic [7:0] d;
        @(negedge txd);
        repeat (bt / 2) @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (bt) @(posedge core_clk);
            if (i < 8) d[i] = txd;
            else if (txd !== 1'b1) bad = 1'b1;
        end
        rxq.push_back(d);
    end
endmodule

// >>> verification/ecps_properties.sv
// Concurrent checks on the ports of the encoder count processing block
`timescale 1ns/10ps
module ecps_properties
    import ecps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire ecps_bus_t bus,
    input wire logic [31:0] rdata,
    input wire logic panel_reset,
    input wire logic preset_stored,
    input wire logic signed [31:0] preset_value,
    input wire logic count_reset,
    input wire logic signed [31:0] count_load,
    input wire logic inch_mode,
    input wire ecps_fmt_t fmt_sel,
    input wire logic pitch_used,
    input wire logic alarm,
    input wire logic txd,
    input wire logic rts_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    a_unmapped_zero: assert property ($past(bus.rd) && $past(bus.addr) > OFS_STATUS
        |-> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_panel_reset: assert property (panel_reset |=> count_reset)
        else $error("panel reset gave no count reset");
    a_reset_single: assert property (count_reset |=> !count_reset)
        else $error("count reset longer than one cycle");
    a_load_value: assert property (count_reset |->
        count_load == ($past(preset_stored) ? $past(preset_value) : 32'sh0))
        else $error("count load not preset or zero");
    a_alarm_single: assert property (alarm |=> !alarm)
        else $error("alarm pulse longer than one cycle");
    a_inch_length: assert property (inch_mode |-> fmt_sel == FMT_LENGTH)
        else $error("inch mode outside length format");
    a_pitch_length: assert property (pitch_used |-> fmt_sel == FMT_LENGTH)
        else $error("pitch used outside length format");
    a_tx_quiet: assert property (!rts_n |-> txd)
        else $error("serial output active with no reply owed");
endmodule
bind ecps_top ecps_properties ecps_properties_i (.core_clk, .rst, .bus, .rdata, .panel_reset,
    .preset_stored, .preset_value, .count_reset, .count_load, .inch_mode, .fmt_sel, .pitch_used,
    .alarm, .txd, .rts_n);

// >>> verification/ecps_top_tb.sv
// Self-checking testbench of the encoder count processing block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ecps_top_tb
    import ecps_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    ecps_bus_t bus = '0;
    logic [31:0] rdata;
    logic sample_valid = 1'b0;
    logic signed [31:0] sample_count = '0;
    logic error_evt = 1'b0;
    logic preset_evt = 1'b0;
    logic panel_reset = 1'b0;
    logic preset_stored = 1'b0;
    logic signed [31:0] preset_value = '0;
    logic count_reset, inch_mode, pitch_used, alarm, rxd, txd, cts_n, rts_n;
    logic signed [31:0] count_load;
    logic signed [39:0] disp_value;
    ecps_res_t res_sel;
    ecps_fmt_t fmt_sel;
    ecps_pitch_t pitch_sel;
    ecps_cfg_t c;
    int failures = 0;
    int checks = 0;
    int n_alarm = 0;
    int n_rst = 0;
    string s = "+000000001000";
    initial forever #4 core_clk = ~core_clk;
    ecps_top #(.DIV_1200(16), .DIV_2400(8), .DIV_4800(4), .DIV_9600(2)) ecps_top_i (
        .core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .sample_valid(sample_valid),
        .sample_count(sample_count), .error_evt(error_evt), .preset_evt(preset_evt),
        .panel_reset(panel_reset), .preset_stored(preset_stored), .preset_value(preset_value),
        .count_reset(count_reset), .count_load(count_load), .disp_value(disp_value),
        .inch_mode(inch_mode), .res_sel(res_sel), .fmt_sel(fmt_sel), .pitch_sel(pitch_sel),
        .pitch_used(pitch_used), .alarm(alarm), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
    ecps_host ecps_host_i (.core_clk(core_clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
    always @(posedge core_clk) begin
        if (alarm === 1'b1) n_alarm++;
        if (count_reset === 1'b1) n_rst++;
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask
    task automatic set();
        wr(OFS_CFG, 32'(c));
        wr(OFS_CTRL, 32'h1);
        #1;
    endtask
    task automatic smp(input logic signed [31:0] v, input logic signed [39:0] e);
        @(posedge core_clk);
        sample_valid <= 1'b1;
        sample_count <= v;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("disp_value", e, disp_value)
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(OFS_ACT, 32'(CFG_RESET));
        rd(8'h1c, 32'h0);
        c = CFG_RESET;
        c.double_cnt = 1'b1;
        wr(OFS_CFG, 32'(c));
        smp(32'sh3e8, 40'sh3e8);
        set();
        smp(32'sh3e8, 40'sh7d0);
        c = CFG_RESET;
        c.avg = AVG_8;
        set();
        for (int i = 0; i < 8; i++) smp(i * 8, i < 7 ? i * 8 : 28);
        c.avg = AVG_1;
        wr(OFS_MAG, 32'h2710);
        set();
        smp(32'sh3e8, 40'sh3e9);
        c.dir_neg = 1'b1;
        set();
        smp(32'sh3e8, 40'sh3e7);
        wr(OFS_MAG, 32'h0);
        set();
        smp(32'sh3e8, 40'sh3e8);
        c.inch = 1'b1;
        set();
        `CHK("inch_mode", 1'b1, inch_mode)
        smp(32'sh3e8, 40'sh313);
        c.fmt = FMT_PULSE;
        set();
        `CHK("inch_mode", 1'b0, inch_mode)
        $display("processing test done");
        for (int b = 0; b < 4; b++) begin
            c = CFG_RESET;
            c.baud = ecps_baud_t'(b);
            set();
            ecps_host_i.bt = 16 >> b;
            ecps_host_i.rxq.delete();
            ecps_host_i.hold = (b == 0);
            ecps_host_i.cmd(CH_Q);
            repeat (300) @(posedge core_clk);
            if (b == 0) `CHK("rts_n", 1'b1, rts_n)
            if (b == 0) `CHK("held chars", 0, ecps_host_i.rxq.size())
            ecps_host_i.hold = 1'b0;
            for (int k = 0; k < 5000 && ecps_host_i.rxq.size() < 15; k++) @(posedge core_clk);
            `CHK("reply chars", 15, ecps_host_i.rxq.size())
            for (int i = 0; i < 15; i++) `CHK("reply", i < 13 ? s[i] : (i == 13 ? CH_CR : CH_LF),
                ecps_host_i.rxq[i])
        end
        `CHK("stop bits", 1'b0, ecps_host_i.bad)
        n_rst = 0;
        ecps_host_i.cmd(CH_R);
        repeat (40) @(posedge core_clk);
        `CHK("serial reset", 1, n_rst)
        $display("serial test done");
        c.absolute = 1'b1;
        c.pitch = PITCH_32;
        set();
        `CHK("pitch_used", 1'b1, pitch_used)
        `CHK("pitch_sel", PITCH_8, pitch_sel)
        preset_stored <= 1'b1;
        preset_value <= 32'sh4d;
        n_alarm = 0;
        @(posedge core_clk);
        panel_reset <= 1'b1;
        @(posedge core_clk);
        panel_reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("pitch_sel", PITCH_32, pitch_sel)
        `CHK("count_load", 32'sh4d, count_load)
        preset_evt <= 1'b1;
        @(posedge core_clk);
        preset_evt <= 1'b0;
        c.alarm_on = 1'b0;
        c.fmt = FMT_PULSE;
        set();
        `CHK("pitch_used", 1'b0, pitch_used)
        error_evt <= 1'b1;
        @(posedge core_clk);
        error_evt <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("alarms", 2, n_alarm)
        $display("reset and alarm test done");
        close_out();
    end
endmodule

// >>> verilog/ecps_pkg.sv
// Constants, types and register map of the encoder count processing block
package ecps_pkg;

    // ------------------------------------------------------------
    // Clock and serial timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned BAUD_1200 = 1200;
    localparam int unsigned BAUD_2400 = 2400;
    localparam int unsigned BAUD_4800 = 4800;
    localparam int unsigned BAUD_9600 = 9600;
    localparam int unsigned FRAME_DATA_BITS = 8;
    localparam int unsigned FRAME_STOP_BITS = 2;
    localparam logic [3:0] TX_LAST_BIT = 4'(FRAME_DATA_BITS + FRAME_STOP_BITS);
    localparam logic [3:0] READING_CHARS = 4'hd;
    localparam logic [3:0] LINE_CHARS = 4'hf;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_MAG = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_ACT = 8'h0c;
    localparam logic [7:0] OFS_DISP_LO = 8'h10;
    localparam logic [7:0] OFS_DISP_HI = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam int unsigned CTRL_SETUP_EXIT = 0;
    localparam int unsigned CTRL_PANEL_RESET = 1;

    // ------------------------------------------------------------
    // ASCII characters of the serial protocol
    // ------------------------------------------------------------
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_Q = 8'h51;
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_MINUS = 8'h2d;

    // Correction magnitude counts in steps of 0.1e-6
    localparam int unsigned CORR_SCALE = 10000000;

    // ------------------------------------------------------------
    // Setting encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FMT_LENGTH, FMT_PULSE, FMT_ANGLE, FMT_RSVD} ecps_fmt_t;
    typedef enum logic [1:0] {AVG_1, AVG_8, AVG_16, AVG_32} ecps_avg_t;
    typedef enum logic [1:0] {BR_1200, BR_2400, BR_4800, BR_9600} ecps_baud_t;
    typedef enum logic [2:0] {PITCH_8, PITCH_10, PITCH_16, PITCH_20, PITCH_32} ecps_pitch_t;
    typedef enum logic [2:0] {
        RES_5U, RES_1U, RES_0P5U, RES_0P1U, RES_0P05U, RES_0P01U, RES_0P001U
    } ecps_res_t;

    typedef struct packed {
        logic absolute;
        logic alarm_on;
        ecps_baud_t baud;
        logic double_cnt;
        logic dir_neg;
        ecps_pitch_t pitch;
        ecps_avg_t avg;
        ecps_res_t res;
        ecps_fmt_t fmt;
        logic inch;
    } ecps_cfg_t;

    localparam ecps_cfg_t CFG_RESET = '{
        absolute: 1'b0, alarm_on: 1'b1, baud: BR_4800, double_cnt: 1'b0, dir_neg: 1'b0,
        pitch: PITCH_8, avg: AVG_1, res: RES_1U, fmt: FMT_LENGTH, inch: 1'b0
    };

    typedef enum logic [1:0] {TX_IDLE, TX_CONV, TX_SEND} ecps_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ecps_rx_st_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ecps_bus_t;

endpackage

// >>> verilog/ecps_top.sv
// Count processing and serial reporting logic of the encoder counter
`timescale 1ns/10ps
// Operation
// - Unit setting selects millimetre or inch display
// - Inch applies only in length format
// - Inch resolution mapped from metric resolution step
// - Display mean of last n samples
// - Averaging count only 1, 8, 16, 32
// - Settings apply on leaving setup screen
// - Pitch used only absolute length mode
// - Pitch is 8, 10, 16, 20, 32 um
// - Pitch change applies only after reset
// - Scale count by correction coefficient
// - Direction adds or subtracts magnitude from one
// - Zero magnitude passes count unchanged
// - Double count shows twice the value
// - Baud 1200/2400/4800/9600, default 4800
// - Alarm on error, power-up, reset, preset
// - Serial frame 8 data, no parity, 2 stop
// - Hardware flow control gates transmission
// - Reading is 13 characters plus CR LF
// - Reset command resets, request sends reading
// - Data input unit cannot reset count
// - Reset zeroes count or loads preset
module ecps_top
    import ecps_pkg::*;
#(
    parameter int unsigned DIV_1200 = CLK_HZ / BAUD_1200,
    parameter int unsigned DIV_2400 = CLK_HZ / BAUD_2400,
    parameter int unsigned DIV_4800 = CLK_HZ / BAUD_4800,
    parameter int unsigned DIV_9600 = CLK_HZ / BAUD_9600
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire ecps_bus_t bus,
    output logic [31:0] rdata,
    input wire logic sample_valid,
    input wire logic signed [31:0] sample_count,
    input wire logic error_evt,
    input wire logic preset_evt,
    input wire logic panel_reset,
    input wire logic preset_stored,
    input wire logic signed [31:0] preset_value,
    output logic count_reset,
    output logic signed [31:0] count_load,
    output logic signed [39:0] disp_value,
    output logic inch_mode,
    output ecps_res_t res_sel,
    output ecps_fmt_t fmt_sel,
    output ecps_pitch_t pitch_sel,
    output logic pitch_used,
    output logic alarm,
    input wire logic rxd,
    output logic txd,
    input wire logic cts_n,
    output logic rts_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ecps_cfg_t cfg_stage;
        logic [15:0] mag_stage;
        ecps_cfg_t cfg_act;
        logic [15:0] mag_act;
        ecps_pitch_t pitch_act;
        logic [31:0][31:0] hist;
        logic [4:0] wp;
        logic [5:0] fill;
        logic signed [36:0] sum;
        logic signed [31:0] avg;
        logic signed [39:0] disp;
        logic [31:0] rdata;
        logic alarm;
        logic cnt_rst;
        logic signed [31:0] load;
        logic pwr_up;
        ecps_tx_st_t tx_st;
        logic [16:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [10:0] tx_sh;
        logic tx_line;
        logic [3:0] tx_idx;
        logic [14:0][7:0] tx_buf;
        logic [39:0] conv_mag;
        logic [3:0] conv_idx;
        ecps_rx_st_t rx_st;
        logic [16:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [23:0] rx_hist;
        logic req_pend;
    } ecps_state_t;

    ecps_state_t st_ff;
    ecps_state_t nxt_st;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [16:0] bit_div(input ecps_baud_t b);
        case (b)
            BR_1200: bit_div = 17'(DIV_1200);
            BR_2400: bit_div = 17'(DIV_2400);
            BR_4800: bit_div = 17'(DIV_4800);
            default: bit_div = 17'(DIV_9600);
        endcase
    endfunction

    function automatic logic [2:0] avg_shift(input ecps_avg_t a);
        case (a)
            AVG_1: avg_shift = 3'h0;
            AVG_8: avg_shift = 3'h3;
            AVG_16: avg_shift = 3'h4;
            default: avg_shift = 3'h5;
        endcase
    endfunction

    // Metric step over inch step: 1/1.016 for the 5, 0.5 and 0.05 um steps, 1/1.27 for all others
    function automatic logic [10:0] inch_num(input ecps_res_t r);
        case (r)
            RES_5U, RES_0P5U, RES_0P05U: inch_num = 11'h3e8;
            default: inch_num = 11'h064;
        endcase
    endfunction

    function automatic logic [10:0] inch_den(input ecps_res_t r);
        case (r)
            RES_5U, RES_0P5U, RES_0P05U: inch_den = 11'h3f8;
            default: inch_den = 11'h07f;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic do_reset;
    logic do_exit;
    logic [5:0] win;
    logic [4:0] old_idx;
    logic signed [36:0] sum_new;
    logic signed [63:0] corr;
    logic signed [63:0] scaled;
    logic [16:0] div;
    logic [7:0] rx_byte;

    always_comb begin
        nxt_st = st_ff;
        do_reset = 1'b0;
        do_exit = 1'b0;
        win = 6'h01 << avg_shift(st_ff.cfg_act.avg);
        old_idx = st_ff.wp - win[4:0];
        sum_new = st_ff.sum;
        corr = 64'sh0;
        scaled = 64'sh0;
        div = bit_div(st_ff.cfg_act.baud);
        rx_byte = 8'h00;
        nxt_st.cnt_rst = 1'b0;
        nxt_st.alarm = 1'b0;
        nxt_st.pwr_up = 1'b0;
        nxt_st.rdata = 32'h0000_0000;

        // ------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------
        if (bus.wr) begin
            case (bus.addr)
                OFS_CFG: nxt_st.cfg_stage = ecps_cfg_t'(bus.wdata[$bits(ecps_cfg_t)-1:0]);
                OFS_MAG: nxt_st.mag_stage = bus.wdata[15:0];
                OFS_CTRL: begin
                    do_exit = bus.wdata[CTRL_SETUP_EXIT];
                    do_reset = bus.wdata[CTRL_PANEL_RESET];
                end
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                OFS_CFG: nxt_st.rdata = 32'(st_ff.cfg_stage);
                OFS_MAG: nxt_st.rdata = 32'(st_ff.mag_stage);
                OFS_ACT: nxt_st.rdata = 32'(st_ff.cfg_act);
                OFS_DISP_LO: nxt_st.rdata = st_ff.disp[31:0];
                OFS_DISP_HI: nxt_st.rdata = 32'(st_ff.disp[39:32]);
                OFS_STATUS: nxt_st.rdata = {28'h0, 1'(st_ff.pitch_act == PITCH_8),
                    st_ff.req_pend, 1'(st_ff.tx_st != TX_IDLE), pitch_used};
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end

        // Staged settings go live on setup exit, pitch waits for a reset
        if (do_exit) begin
            nxt_st.cfg_act = st_ff.cfg_stage;
            nxt_st.mag_act = st_ff.mag_stage;
            if (st_ff.cfg_stage.avg != st_ff.cfg_act.avg) begin
                nxt_st.fill = 6'h00;
                nxt_st.sum = 37'sh0;
            end
        end

        if (st_ff.tx_st == TX_IDLE) nxt_st.req_pend = 1'b0;
        // ------------------------------------------------------------
        // Serial receive, command decode
        // ------------------------------------------------------------
        case (st_ff.rx_st)
            RX_IDLE: begin
                if (!rxd) begin
                    nxt_st.rx_st = RX_START;
                    nxt_st.rx_cnt = (div >> 1) - 17'h1;
                end
            end
            RX_START: begin
                if (st_ff.rx_cnt == 17'h0) begin
                    nxt_st.rx_st = rxd ? RX_IDLE : RX_DATA;
                    nxt_st.rx_cnt = div - 17'h1;
                    nxt_st.rx_bit = 4'h0;
                end else begin
                    nxt_st.rx_cnt = st_ff.rx_cnt - 17'h1;
                end
            end
            RX_DATA: begin
                if (st_ff.rx_cnt == 17'h0) begin
                    nxt_st.rx_sh = {rxd, st_ff.rx_sh[7:1]};
                    nxt_st.rx_cnt = div - 17'h1;
                    nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                    if (st_ff.rx_bit == 4'(FRAME_DATA_BITS - 1)) begin
                        nxt_st.rx_st = RX_STOP;
                    end
                end else begin
                    nxt_st.rx_cnt = st_ff.rx_cnt - 17'h1;
                end
            end
            RX_STOP: begin
                if (st_ff.rx_cnt == 17'h0) begin
                    nxt_st.rx_st = RX_IDLE;
                    if (rxd) begin
                        rx_byte = st_ff.rx_sh;
                        nxt_st.rx_hist = {st_ff.rx_hist[15:0], rx_byte};
                        // Command ends at LF after CR
                        if (rx_byte == CH_LF && st_ff.rx_hist[7:0] == CH_CR
                                && st_ff.rx_hist[15:8] == CH_X) begin
                            if (st_ff.rx_hist[23:16] == CH_R) begin
                                do_reset = 1'b1;
                            end
                            if (st_ff.rx_hist[23:16] == CH_Q) begin
                                nxt_st.req_pend = 1'b1;
                            end
                        end
                    end
                end else begin
                    nxt_st.rx_cnt = st_ff.rx_cnt - 17'h1;
                end
            end
            default: nxt_st.rx_st = RX_IDLE;
        endcase

        // Only the serial command and the panel may reset the count
        do_reset = do_reset | panel_reset;

        if (do_reset) begin
            nxt_st.cnt_rst = 1'b1;
            nxt_st.load = preset_stored ? preset_value : 32'sh0;
            nxt_st.pitch_act = st_ff.cfg_act.pitch;
            nxt_st.fill = 6'h00;
            nxt_st.sum = 37'sh0;
            nxt_st.avg = preset_stored ? preset_value : 32'sh0;
        end else if (sample_valid) begin
            // ------------------------------------------------------------
            // Moving average over a ring of the last 32 samples
            // ------------------------------------------------------------
            sum_new = st_ff.sum + 37'(sample_count);
            if (st_ff.fill == win) begin
                sum_new = sum_new - 37'(signed'(st_ff.hist[old_idx]));
            end else begin
                nxt_st.fill = st_ff.fill + 6'h01;
            end
            nxt_st.hist[st_ff.wp] = sample_count;
            nxt_st.wp = st_ff.wp + 5'h01;
            nxt_st.sum = sum_new;
            // Raw samples show until the window has filled
            if (st_ff.fill == win || st_ff.fill + 6'h01 == win) begin
                nxt_st.avg = 32'(sum_new >>> avg_shift(st_ff.cfg_act.avg));
            end else begin
                nxt_st.avg = sample_count;
            end
        end

        // ------------------------------------------------------------
        // Correction, doubling, unit conversion
        // ------------------------------------------------------------
        corr = (64'(st_ff.avg) * $signed({48'h0, st_ff.mag_act}))
            / $signed(64'(CORR_SCALE));
        if (st_ff.mag_act == 16'h0) begin
            scaled = 64'(st_ff.avg);
        end else if (st_ff.cfg_act.dir_neg) begin
            scaled = 64'(st_ff.avg) - corr;
        end else begin
            scaled = 64'(st_ff.avg) + corr;
        end
        if (st_ff.cfg_act.double_cnt) begin
            scaled = scaled <<< 1;
        end
        if (inch_mode) begin
            scaled = (scaled * $signed({53'h0, inch_num(st_ff.cfg_act.res)}))
                / $signed({53'h0, inch_den(st_ff.cfg_act.res)});
        end
        nxt_st.disp = scaled[39:0];

        // ------------------------------------------------------------
        // Alarm
        // ------------------------------------------------------------
        nxt_st.alarm = st_ff.cfg_act.alarm_on
            & (error_evt | st_ff.pwr_up | do_reset | preset_evt);

        // ------------------------------------------------------------
        // Serial transmit of a reading
        // ------------------------------------------------------------
        case (st_ff.tx_st)
            TX_IDLE: begin
                nxt_st.tx_line = 1'b1;
                if (st_ff.req_pend) begin
                    nxt_st.tx_st = TX_CONV;
                    nxt_st.tx_buf[0] = st_ff.disp[39] ? CH_MINUS : CH_PLUS;
                    nxt_st.conv_mag = st_ff.disp[39] ? 40'(-st_ff.disp) : st_ff.disp;
                    nxt_st.conv_idx = READING_CHARS - 4'h1;
                    nxt_st.tx_buf[13] = CH_CR;
                    nxt_st.tx_buf[14] = CH_LF;
                end
            end
            TX_CONV: begin
                // One decimal digit per cycle, least significant first
                nxt_st.tx_buf[st_ff.conv_idx] = CH_ZERO + 8'(st_ff.conv_mag % 40'd10);
                nxt_st.conv_mag = st_ff.conv_mag / 40'd10;
                nxt_st.conv_idx = st_ff.conv_idx - 4'h1;
                if (st_ff.conv_idx == 4'h1) begin
                    nxt_st.tx_st = TX_SEND;
                    nxt_st.tx_idx = 4'h0;
                    nxt_st.tx_bit = TX_LAST_BIT + 4'h1;
                end
            end
            TX_SEND: begin
                if (st_ff.tx_bit > TX_LAST_BIT) begin
                    // Each character waits for clear to send
                    if (st_ff.tx_idx == LINE_CHARS) begin
                        nxt_st.tx_st = TX_IDLE;
                    end else if (!cts_n) begin
                        nxt_st.tx_sh = {2'b11, st_ff.tx_buf[st_ff.tx_idx], 1'b0};
                        nxt_st.tx_bit = 4'h0;
                        nxt_st.tx_cnt = div - 17'h1;
                        nxt_st.tx_line = 1'b0;
                    end
                end else if (st_ff.tx_cnt == 17'h0) begin
                    nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                    nxt_st.tx_cnt = div - 17'h1;
                    if (st_ff.tx_bit == TX_LAST_BIT) begin
                        nxt_st.tx_idx = st_ff.tx_idx + 4'h1;
                        nxt_st.tx_line = 1'b1;
                    end else begin
                        nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
                        nxt_st.tx_line = st_ff.tx_sh[1];
                    end
                end else begin
                    nxt_st.tx_cnt = st_ff.tx_cnt - 17'h1;
                end
            end
            default: nxt_st.tx_st = TX_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.cfg_stage <= CFG_RESET;
            st_ff.cfg_act <= CFG_RESET;
            st_ff.pitch_act <= PITCH_8;
            st_ff.tx_line <= 1'b1;
            st_ff.tx_bit <= TX_LAST_BIT + 4'h1;
            st_ff.pwr_up <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = st_ff.rdata;
    assign count_reset = st_ff.cnt_rst;
    assign count_load = st_ff.load;
    assign disp_value = st_ff.disp;
    assign inch_mode = st_ff.cfg_act.inch && st_ff.cfg_act.fmt == FMT_LENGTH;
    assign res_sel = st_ff.cfg_act.res;
    assign fmt_sel = st_ff.cfg_act.fmt;
    assign pitch_sel = st_ff.pitch_act;
    assign pitch_used = st_ff.cfg_act.absolute && st_ff.cfg_act.fmt == FMT_LENGTH;
    assign alarm = st_ff.alarm;
    assign txd = st_ff.tx_line;
    // Hold the host off while a reading is owed
    assign rts_n = st_ff.req_pend | (st_ff.tx_st != TX_IDLE);

endmodule
